/* pkg/ksm_pkg.sv */
// Purpose: shared constants for the keying signal mixer
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   offsets are byte addresses
package ksm_pkg;

  localparam int unsigned ADDR_W = 8;

  // register offsets
  localparam logic [ADDR_W-1:0] MIXER_CONTROL_REG0_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] MIXER_CONTROL_REG1_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] MODULATOR_SOURCE_OFS   = 8'h08;
  localparam logic [ADDR_W-1:0] HIGH_CARRIER_OFS       = 8'h0C;
  localparam logic [ADDR_W-1:0] LOW_CARRIER_OFS        = 8'h10;

  // control register 0 fields
  localparam int unsigned C0_ENABLE_BIT = 7;
  localparam int unsigned C0_STATUS_BIT = 5;
  localparam int unsigned C0_OUTINV_BIT = 4;
  localparam int unsigned C0_SWBIT_BIT  = 0;

  // control register 1 fields
  localparam int unsigned C1_HI_INV_BIT  = 5;
  localparam int unsigned C1_HI_SYNC_BIT = 4;
  localparam int unsigned C1_LO_INV_BIT  = 1;
  localparam int unsigned C1_LO_SYNC_BIT = 0;

  // reset values
  localparam logic [7:0] CONTROL0_RST = 8'h00;
  localparam logic [7:0] CONTROL1_RST = 8'h00;
  localparam logic [4:0] MOD_SEL_RST  = 5'h00;
  localparam logic [3:0] CAR_SEL_RST  = 4'h0;

  // selection codes
  localparam logic [4:0] MOD_SEL_PIN = 5'h00;
  localparam logic [4:0] MOD_SEL_SW  = 5'h01;
  localparam logic [4:0] MOD_SEL_P0  = 5'h02;
  localparam logic [4:0] MOD_SEL_MAX = 5'h13;
  localparam logic [3:0] CAR_SEL_PIN = 4'h0;
  localparam logic [3:0] CAR_SEL_CLK = 4'h1;
  localparam logic [3:0] CAR_SEL_OSC = 4'hB;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {KSM_CAR_PIN, KSM_CAR_INT} ksm_car_kind_t;

endpackage

/* pkg/ksm_cfg_if.sv */
// Purpose: configuration and pin path between register file and mixer core
// Assumes: single clock domain
// Notes:   ctrl drives settings, core returns the pin level
`timescale 1ns/1ps
`default_nettype none
interface ksm_cfg_if;
  logic       enable;
  logic       sw_bit;
  logic       out_inv;
  logic       hi_inv;
  logic       lo_inv;
  logic       hi_sync;
  logic       lo_sync;
  logic [4:0] mod_sel;
  logic [3:0] hi_sel;
  logic [3:0] lo_sel;
  logic       pin_out;

  modport ctrl (output enable, sw_bit, out_inv, hi_inv, lo_inv, hi_sync, lo_sync,
                output mod_sel, hi_sel, lo_sel, input pin_out);
  modport core (input enable, sw_bit, out_inv, hi_inv, lo_inv, hi_sync, lo_sync,
                input mod_sel, hi_sel, lo_sel, output pin_out);
endinterface
`default_nettype wire

/* verilog/ksm_mixer.sv */
// Purpose: source selection, carrier sync and output mixing
// Assumes: carriers and modulator sampled by aclk only for edge tracking
// Notes:   the data path to the pin is combinational
`timescale 1ns/1ps
`default_nettype none
module ksm_mixer #(
  parameter int unsigned MOD_PERIPH_N = 18,
  parameter int unsigned CAR_SRC_N    = 15
) (
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // configuration and pin
  ksm_cfg_if.core                      cfg,
  // signal sources
  input  wire logic                    modulator_pin_in,
  input  wire logic [MOD_PERIPH_N-1:0] mod_periph_in,
  input  wire logic                    high_carrier_pin_in,
  input  wire logic                    low_carrier_pin_in,
  input  wire logic [CAR_SRC_N-1:0]    carrier_src_in
);
  import ksm_pkg::*;

  function automatic logic car_pick(input logic [3:0] sel, input logic pin,
                                    input logic [CAR_SRC_N-1:0] src);
    logic [3:0] idx;
    idx = sel - CAR_SEL_CLK;
    car_pick = (sel == CAR_SEL_PIN) ? pin : src[idx];
  endfunction

  logic high_carrier_signal;
  logic low_carrier_signal;
  logic mod_raw;
  logic modulator_signal;
  logic sel_high_r;
  logic high_carrier_signal_d_r;
  logic low_carrier_signal_d_r;
  logic hold;
  logic fall_cur;
  logic mix;
  logic [4:0] midx;

  // disabled: carriers to ground, modulator to the software bit
  assign high_carrier_signal = cfg.enable &
    (car_pick(cfg.hi_sel, high_carrier_pin_in, carrier_src_in) ^ cfg.hi_inv);
  assign low_carrier_signal = cfg.enable &
    (car_pick(cfg.lo_sel, low_carrier_pin_in, carrier_src_in) ^ cfg.lo_inv);

  assign midx = cfg.mod_sel - MOD_SEL_P0;
  always_comb begin
    if (!cfg.enable) begin
      mod_raw = cfg.sw_bit;
    end else if (cfg.mod_sel == MOD_SEL_PIN) begin
      mod_raw = modulator_pin_in;
    end else if (cfg.mod_sel == MOD_SEL_SW) begin
      mod_raw = cfg.sw_bit;
    end else if (cfg.mod_sel <= MOD_SEL_MAX) begin
      mod_raw = mod_periph_in[midx];
    end else begin
      mod_raw = 1'b0;
    end
  end

  // a pending switch waits for the carrier in use to fall
  assign fall_cur = sel_high_r ? (high_carrier_signal_d_r & ~high_carrier_signal)
                               : (low_carrier_signal_d_r & ~low_carrier_signal);
  assign hold = (mod_raw != sel_high_r) &&
                (sel_high_r ? cfg.hi_sync : cfg.lo_sync) && !fall_cur;
  assign modulator_signal = hold ? sel_high_r : mod_raw;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_high_r <= 1'b0;
    end else begin
      sel_high_r <= modulator_signal;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      high_carrier_signal_d_r <= 1'b0;
      low_carrier_signal_d_r <= 1'b0;
    end else begin
      high_carrier_signal_d_r <= high_carrier_signal;
      low_carrier_signal_d_r <= low_carrier_signal;
    end
  end

  // not registered so the output rate is not bounded by aclk
  assign mix = (modulator_signal & high_carrier_signal) |
               (~modulator_signal & low_carrier_signal);
  assign cfg.pin_out = (cfg.enable & mix) ^ cfg.out_inv;

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_disabled_idle: assert property (!cfg.enable |-> cfg.pin_out == cfg.out_inv)
    else $error("disabled output not idle");
  chk_high_mix: assert property (cfg.enable && !cfg.out_inv && modulator_signal
      |-> cfg.pin_out == high_carrier_signal)
    else $error("high carrier not mixed");
  chk_sw_source: assert property (cfg.enable && cfg.mod_sel == MOD_SEL_SW
      && !cfg.hi_sync && !cfg.lo_sync |-> modulator_signal == cfg.sw_bit)
    else $error("software bit not used");
  chk_sync_wait: assert property (cfg.hi_sync && sel_high_r && !mod_raw
      && high_carrier_signal && $stable(high_carrier_signal) |-> modulator_signal)
    else $error("switched before carrier fell");
  chk_nosync_follow: assert property (!cfg.hi_sync && !cfg.lo_sync
      |-> modulator_signal == mod_raw)
    else $error("unsynced modulator lags");

  cov_sync_switch: cover property (cfg.hi_sync && hold ##[1:20] !hold);
  cov_low_mix: cover property (cfg.enable && !modulator_signal && low_carrier_signal);
endmodule
`default_nettype wire

/* verilog/ksm_top.sv */
// Purpose: keying signal mixer with AXI4-Lite register access
// Assumes: aclk 200 MHz, all source inputs synchronous to aclk
// Notes:   modulated_output_pin is combinational from the sources
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ksm_top #(
  parameter int unsigned MOD_PERIPH_N = 18,
  parameter int unsigned CAR_SRC_N    = 15
) (
  // clock and reset
  input  wire logic                         aclk,
  input  wire logic                         aresetn,
  // axi4-lite write address and data
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [ksm_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]                   s_axi_awprot,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  // axi4-lite write response
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  output logic [1:0]                        s_axi_bresp,
  // axi4-lite read
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  input  wire logic [ksm_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]                   s_axi_arprot,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  // signal sources
  input  wire logic                         modulator_pin_in,
  input  wire logic [MOD_PERIPH_N-1:0]      mod_periph_in,
  input  wire logic                         high_carrier_pin_in,
  input  wire logic                         low_carrier_pin_in,
  input  wire logic [CAR_SRC_N-1:0]         carrier_src_in,
  // modulated output
  output logic                              modulated_output_pin
);
  import ksm_pkg::*;

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a == MIXER_CONTROL_REG0_OFS) || (a == MIXER_CONTROL_REG1_OFS) ||
              (a == MODULATOR_SOURCE_OFS) || (a == HIGH_CARRIER_OFS) ||
              (a == LOW_CARRIER_OFS);
  endfunction

  ksm_cfg_if cfg ();

  logic [7:0]        control0_r;
  logic [7:0]        control1_r;
  logic [4:0]        mod_sel_r;
  logic [3:0]        hi_sel_r;
  logic [3:0]        lo_sel_r;
  logic              status_r;
  logic              aw_got_r;
  logic              w_got_r;
  logic [ADDR_W-1:0] waddr_r;
  logic [7:0]        wbyte_r;
  logic              wstrb0_r;
  logic              do_write;
  logic [31:0]       rd_nxt;

  // settings stay in their registers while disabled
  assign cfg.enable  = control0_r[C0_ENABLE_BIT];
  assign cfg.sw_bit  = control0_r[C0_SWBIT_BIT];
  assign cfg.out_inv = control0_r[C0_OUTINV_BIT];
  assign cfg.hi_inv  = control1_r[C1_HI_INV_BIT];
  assign cfg.lo_inv  = control1_r[C1_LO_INV_BIT];
  assign cfg.hi_sync = control1_r[C1_HI_SYNC_BIT];
  assign cfg.lo_sync = control1_r[C1_LO_SYNC_BIT];
  assign cfg.mod_sel = mod_sel_r;
  assign cfg.hi_sel  = hi_sel_r;
  assign cfg.lo_sel  = lo_sel_r;

  ksm_mixer #(
    .MOD_PERIPH_N (MOD_PERIPH_N),
    .CAR_SRC_N    (CAR_SRC_N)
  ) u_mixer (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .cfg                 (cfg.core),
    .modulator_pin_in    (modulator_pin_in),
    .mod_periph_in       (mod_periph_in),
    .high_carrier_pin_in (high_carrier_pin_in),
    .low_carrier_pin_in  (low_carrier_pin_in),
    .carrier_src_in      (carrier_src_in)
  );

  // left unregistered on purpose: a flop would cap the carrier rate
  assign modulated_output_pin = cfg.pin_out;

  // write address and data, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      waddr_r       <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_got_r      <= 1'b1;
      s_axi_awready <= 1'b0;
      waddr_r       <= s_axi_awaddr;
    end else if (do_write) begin
      aw_got_r      <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_r      <= 1'b0;
      s_axi_wready <= 1'b1;
      wbyte_r      <= 8'h00;
      wstrb0_r     <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_got_r      <= 1'b1;
      s_axi_wready <= 1'b0;
      wbyte_r      <= s_axi_wdata[7:0];
      wstrb0_r     <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_got_r      <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_ok(waddr_r) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; only byte lane 0 carries data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control0_r <= CONTROL0_RST;
      control1_r <= CONTROL1_RST;
      mod_sel_r  <= MOD_SEL_RST;
      hi_sel_r   <= CAR_SEL_RST;
      lo_sel_r   <= CAR_SEL_RST;
    end else if (do_write && wstrb0_r) begin
      unique case (waddr_r)
        MIXER_CONTROL_REG0_OFS: begin
          control0_r[C0_ENABLE_BIT] <= wbyte_r[C0_ENABLE_BIT];
          control0_r[C0_OUTINV_BIT] <= wbyte_r[C0_OUTINV_BIT];
          control0_r[C0_SWBIT_BIT]  <= wbyte_r[C0_SWBIT_BIT];
        end
        MIXER_CONTROL_REG1_OFS: begin
          control1_r[C1_HI_INV_BIT]  <= wbyte_r[C1_HI_INV_BIT];
          control1_r[C1_HI_SYNC_BIT] <= wbyte_r[C1_HI_SYNC_BIT];
          control1_r[C1_LO_INV_BIT]  <= wbyte_r[C1_LO_INV_BIT];
          control1_r[C1_LO_SYNC_BIT] <= wbyte_r[C1_LO_SYNC_BIT];
        end
        MODULATOR_SOURCE_OFS: mod_sel_r <= wbyte_r[4:0];
        HIGH_CARRIER_OFS:     hi_sel_r  <= wbyte_r[3:0];
        LOW_CARRIER_OFS:      lo_sel_r  <= wbyte_r[3:0];
        default: ;
      endcase
    end
  end

  // output bit snapshot; may miss fast carrier activity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_r <= 1'b0;
    end else begin
      status_r <= cfg.pin_out;
    end
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (s_axi_araddr)
      MIXER_CONTROL_REG0_OFS: begin
        rd_nxt[C0_ENABLE_BIT] = control0_r[C0_ENABLE_BIT];
        rd_nxt[C0_STATUS_BIT] = status_r;
        rd_nxt[C0_OUTINV_BIT] = control0_r[C0_OUTINV_BIT];
        rd_nxt[C0_SWBIT_BIT]  = control0_r[C0_SWBIT_BIT];
      end
      MIXER_CONTROL_REG1_OFS: rd_nxt[7:0] = control1_r;
      MODULATOR_SOURCE_OFS:   rd_nxt[4:0] = mod_sel_r;
      HIGH_CARRIER_OFS:       rd_nxt[3:0] = hi_sel_r;
      LOW_CARRIER_OFS:        rd_nxt[3:0] = lo_sel_r;
      default: ;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_nxt;
      s_axi_rresp   <= addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_reset_disables: assert property ($rose(aresetn) |-> !cfg.enable
      && mod_sel_r == MOD_SEL_RST)
    else $error("mixer not disabled after reset");
  chk_select_kept: assert property ($fell(cfg.enable) ##1 !cfg.enable && !do_write
      |-> $stable(mod_sel_r) && $stable(hi_sel_r))
    else $error("selection changed while disabled");
  chk_enable_write: assert property (do_write && wstrb0_r
      && waddr_r == MIXER_CONTROL_REG0_OFS |=> cfg.enable == $past(wbyte_r[C0_ENABLE_BIT]))
    else $error("enable write not applied");
  chk_status_track: assert property (##1 status_r == $past(cfg.pin_out))
    else $error("status bit lags output");
  chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");

  cov_enable_on: cover property ($rose(cfg.enable));
  cov_bad_write: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule
`default_nettype wire

/* dv/ksm_pin_load.sv */
// Purpose: external load on the modulated pin, counts keyed pulses
// Assumes: pin level settles between transitions of the driven carrier
// Notes:   counts on pin edges, not aclk, so fast carriers still register
`timescale 1ns/1ps
`default_nettype none
module ksm_pin_load (
  // pin and control
  input  wire logic pin,
  input  wire logic clr,
  // observation
  output var  int   rises
);
  // asynchronous count, the load does not see the register clock
  always @(posedge pin or posedge clr) begin
    if (clr) begin
      rises <= 0;
    end else begin
      rises <= rises + 1;
    end
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Purpose: self-checking bench for the keying signal mixer
// Assumes: registers reached over AXI4-Lite, sources driven directly
// Notes:   bready and rready held high, responses taken when they appear
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ksm_pkg::*;
  logic        aclk, aresetn, awv, wv, arv, bready, rready, clr;
  logic        awr, wrd, bv, arr, rv, pin, mpin, hp, lp;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic [17:0] mp;
  logic [14:0] cs;
  int          rises, err_total, checks;
  localparam logic [7:0] REGS [5] = '{MIXER_CONTROL_REG0_OFS, MIXER_CONTROL_REG1_OFS,
    MODULATOR_SOURCE_OFS, HIGH_CARRIER_OFS, LOW_CARRIER_OFS};

  ksm_top i_ksm_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
    .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_bresp(br),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rv), .s_axi_rready(rready), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .modulator_pin_in(mpin), .mod_periph_in(mp), .high_carrier_pin_in(hp),
    .low_carrier_pin_in(lp), .carrier_src_in(cs), .modulated_output_pin(pin));

  ksm_pin_load i_ksm_pin_load (.pin(pin), .clr(clr), .rises(rises));

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic complete_run();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic fail_to();
    err_total++;
    $display("[ERR] %0t wait ran out", $time);
    complete_run();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask

  // a few edges let the sync tracker see a carrier fall
  task automatic pin_is(input logic e, input string what);
    cyc(3);
    chk(32'(pin), 32'(e), what);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    int   n;
    logic aw_p;
    logic w_p;
    n = 0;
    aw_p = 1'b1;
    w_p = 1'b1;
    awa <= a;
    wd <= {24'h00_0000, d};
    ws <= 4'h1;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw_p && awr === 1'b1) begin
        aw_p = 1'b0;
        awv <= 1'b0;
      end
      if (w_p && wrd === 1'b1) begin
        w_p = 1'b0;
        wv <= 1'b0;
      end
    end while (bv !== 1'b1 && n < 50);
    if (n >= 50) fail_to();
    else chk(32'(br), 32'(er), "bresp");
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    if (n >= 50) fail_to();
    else begin
      chk(rdat, exp, "rdata");
      chk(32'(rr), 32'(er), "rresp");
    end
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    fail_to();
  end

  initial begin
    aresetn = 1'b0;
    {awv, wv, arv, mpin, hp, lp} = '0;
    {bready, rready, clr} = 3'h7;
    {awa, ara, wd, ws, mp, cs} = '0;
    err_total = 0;
    checks = 0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    clr <= 1'b0;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(REGS[i], 32'h0000_0000);
    rd(8'h14, 32'h0000_0000, RESP_SLVERR);
    wr(8'h14, 8'hFF, RESP_SLVERR);
    pin_is(1'b0, "reset pin");
    // disabled: live sources must not reach the pin
    hp <= 1'b1;
    lp <= 1'b1;
    mpin <= 1'b1;
    wr(MIXER_CONTROL_REG0_OFS, 8'h01);
    pin_is(1'b0, "disabled pin");
    wr(MIXER_CONTROL_REG0_OFS, 8'h11);
    pin_is(1'b1, "disabled inverted");
    wr(MODULATOR_SOURCE_OFS, {3'h0, MOD_SEL_SW});
    wr(MIXER_CONTROL_REG0_OFS, 8'h81);
    lp <= 1'b0;
    pin_is(1'b1, "sw bit high carrier");
    hp <= 1'b0;
    pin_is(1'b0, "and with carrier");
    wr(MIXER_CONTROL_REG0_OFS, 8'h80);
    lp <= 1'b1;
    pin_is(1'b1, "low carrier used");
    // modulator sweep: only the addressed source may count
    hp <= 1'b1;
    lp <= 1'b0;
    for (int c = 2; c < 20; c++) begin
      wr(MODULATOR_SOURCE_OFS, 8'(c));
      mp <= 18'h0_0001 << (c - 2);
      pin_is(1'b1, "mod source set");
      mp <= ~(18'h0_0001 << (c - 2));
      pin_is(1'b0, "mod source clear");
    end
    mp <= '1;
    for (int c = 20; c < 32; c++) begin
      wr(MODULATOR_SOURCE_OFS, 8'(c));
      pin_is(1'b0, "reserved mod code");
    end
    wr(MODULATOR_SOURCE_OFS, {3'h0, MOD_SEL_PIN});
    pin_is(1'b1, "mod pin high");
    mpin <= 1'b0;
    pin_is(1'b0, "mod pin low");
    wr(MODULATOR_SOURCE_OFS, {3'h0, MOD_SEL_SW});
    // carrier sweep, low then high carrier
    for (int k = 0; k < 2; k++) begin
      wr(MIXER_CONTROL_REG0_OFS, k ? 8'h81 : 8'h80);
      for (int c = 1; c < 16; c++) begin
        wr(k ? HIGH_CARRIER_OFS : LOW_CARRIER_OFS, 8'(c));
        cs <= 15'h0001 << (c - 1);
        pin_is(1'b1, "carrier set");
        cs <= ~(15'h0001 << (c - 1));
        pin_is(1'b0, "carrier clear");
      end
    end
    cs <= '0;
    wr(MIXER_CONTROL_REG1_OFS, 8'h20);
    pin_is(1'b1, "high inverted");
    wr(MIXER_CONTROL_REG0_OFS, 8'h91);
    pin_is(1'b0, "output inverted");
    wr(MIXER_CONTROL_REG0_OFS, 8'h90);
    wr(MIXER_CONTROL_REG1_OFS, 8'h02);
    pin_is(1'b0, "low inverted");
    wr(MIXER_CONTROL_REG0_OFS, 8'h10);
    pin_is(1'b1, "gated then inverted");
    rd(HIGH_CARRIER_OFS, 32'h0000_000F);
    rd(MODULATOR_SOURCE_OFS, 32'h0000_0001);
    wr(MIXER_CONTROL_REG1_OFS, 8'h00);
    wr(MIXER_CONTROL_REG0_OFS, 8'h80);
    cs <= 15'h4000;
    pin_is(1'b1, "selection reapplied");
    rd(MIXER_CONTROL_REG0_OFS, 32'h0000_00A0);
    // sync: leaving a carrier waits for its fall only where enabled
    wr(HIGH_CARRIER_OFS, 8'h00);
    wr(LOW_CARRIER_OFS, 8'h00);
    wr(MIXER_CONTROL_REG1_OFS, 8'h10);
    wr(MIXER_CONTROL_REG0_OFS, 8'h81);
    hp <= 1'b1;
    lp <= 1'b0;
    wr(MIXER_CONTROL_REG0_OFS, 8'h80);
    pin_is(1'b1, "held on high carrier");
    hp <= 1'b0;
    lp <= 1'b1;
    pin_is(1'b1, "switched after fall");
    wr(MIXER_CONTROL_REG1_OFS, 8'h01);
    wr(MIXER_CONTROL_REG0_OFS, 8'h81);
    pin_is(1'b1, "held on low carrier");
    lp <= 1'b0;
    hp <= 1'b1;
    pin_is(1'b1, "switched to high");
    wr(MIXER_CONTROL_REG0_OFS, 8'h80);
    pin_is(1'b0, "unsynced switch");
    // keyed burst into the load, then silence; sync off so the switch is immediate
    wr(MIXER_CONTROL_REG1_OFS, 8'h00);
    wr(MIXER_CONTROL_REG0_OFS, 8'h81);
    hp <= 1'b0;
    clr <= 1'b1;
    cyc(2);
    clr <= 1'b0;
    cyc(1);
    repeat (16) begin
      hp <= ~hp;
      @(posedge aclk);
    end
    wr(MIXER_CONTROL_REG0_OFS, 8'h80);
    repeat (16) begin
      hp <= ~hp;
      @(posedge aclk);
    end
    chk(32'(rises), 32'h0000_0008, "keyed pulses");
    // reset in mid-run
    aresetn <= 1'b0;
    cyc(2);
    aresetn <= 1'b1;
    cyc(1);
    for (int i = 0; i < 5; i++) rd(REGS[i], 32'h0000_0000);
    pin_is(1'b0, "pin after reset");
    complete_run();
  end
endmodule
`default_nettype wire
